//--- pkg/fdd_seq_defs.svh
/*
  timing constants and register offsets for the drive interface sequencer.
  assumes the includer works at a 200 MHz hclk.
*/
`ifndef FDD_SEQ_DEFS_SVH
`define FDD_SEQ_DEFS_SVH

// ----------------------------------------
// clock and delays
// ----------------------------------------
`define CLK_MHZ          200
`define SPINUP_MS        250
`define STEP_MOTION_MS   5
`define STEP_SETTLE_MS   15
`define STEP_TOTAL_MS    (`STEP_MOTION_MS + `STEP_SETTLE_MS)
`define READ_SETTLE_US   100
`define TRIM_ON_US       390
`define TRIM_OFF_US      800
`define STEP_PULSE_US    1
`define SPINUP_CYC       (`SPINUP_MS * 1000 * `CLK_MHZ)
`define STEP_CYC         (`STEP_TOTAL_MS * 1000 * `CLK_MHZ)
`define READ_SETTLE_CYC  (`READ_SETTLE_US * `CLK_MHZ)
`define TRIM_BUSY_CYC    ((`TRIM_ON_US + `TRIM_OFF_US) * `CLK_MHZ)
`define STEP_PULSE_CYC   (`STEP_PULSE_US * `CLK_MHZ)

// ----------------------------------------
// register offsets
// ----------------------------------------
`define REG_CTRL    8'h00
`define REG_CMD     8'h04
`define REG_STATUS  8'h08
`define REG_WDATA   8'h0C
`define REG_RCOUNT  8'h10

// ----------------------------------------
// control fields
// ----------------------------------------
`define CTRL_DRIVE   0
`define CTRL_MOTOR   1
`define CTRL_SIDE    2
`define CTRL_DIR     3
`define CTRL_RESET   8'h00

// ----------------------------------------
// command codes
// ----------------------------------------
`define CMD_STEP       2'h1
`define CMD_WR_START   2'h2
`define CMD_WR_STOP    2'h3

`endif

//--- pkg/fdd_seq_pkg.sv
/*
  types shared by the drive interface sequencer.
  assumes nothing of its surroundings.
*/
package fdd_seq_pkg;
  typedef enum logic [1:0] {
    wr_idle  = 2'h0,
    wr_gate  = 2'h1,
    wr_tail  = 2'h3,
    wr_trim  = 2'h2
  } wr_state_t;

  typedef struct packed {
    logic       sel_n;
    logic       motor_n;
    logic       side;
    logic       dir;
    logic       step_n;
    logic       wr_en_n;
    logic       wr_data_n;
  } drive_ctl_t;

  typedef struct packed {
    logic index_n;
    logic trk0_n;
    logic wprot_n;
    logic rdata_n;
  } drive_sts_t;
endpackage : fdd_seq_pkg

//--- core/fdd_seq.sv
/*
  host-side sequencer for two flexible disc drives, driven over ahb-lite.
  assumes one 200 MHz clock; drive status pins are asynchronous.
*/
`timescale 1ns/1ps
`default_nettype none
`include "fdd_seq_defs.svh"

module fdd_seq #(
  parameter int unsigned SPINUP_CYC  = `SPINUP_CYC,
  parameter int unsigned STEP_CYC    = `STEP_CYC,
  parameter int unsigned BUSY_CYC    = `TRIM_BUSY_CYC,
  parameter int unsigned RSETTLE_CYC = `READ_SETTLE_CYC
) (
  input  wire logic                     hclk,
  input  wire logic                     hresetn,
  input  wire logic                     hsel,
  input  wire logic [31:0]              haddr,
  input  wire logic [1:0]               htrans,
  input  wire logic                     hwrite,
  input  wire logic [2:0]               hsize,
  input  wire logic [31:0]              hwdata,
  input  wire logic                     hready,
  output logic      [31:0]              hrdata,
  output logic                          hreadyout,
  output logic                          hresp,
  output fdd_seq_pkg::drive_ctl_t       drv0_ctl,
  output fdd_seq_pkg::drive_ctl_t       drv1_ctl,
  input  wire fdd_seq_pkg::drive_sts_t  drv0_sts,
  input  wire fdd_seq_pkg::drive_sts_t  drv1_sts,
  output logic                          rd_data_n,
  output logic                          read_ok
);
  import fdd_seq_pkg::*;

  localparam int unsigned PULSE_CYC = `STEP_PULSE_CYC;

  // ----------------------------------------
  // bus address phase capture
  // ----------------------------------------
  logic        wr_ph_ff;
  logic        rd_ph_ff;
  logic [7:0]  addr_ff;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ph_ff <= 1'b0;
      rd_ph_ff <= 1'b0;
      addr_ff  <= 8'h00;
    end else if (hready) begin
      wr_ph_ff <= hsel && htrans[1] && hwrite;
      rd_ph_ff <= hsel && htrans[1] && !hwrite;
      addr_ff  <= haddr[7:0];
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // ----------------------------------------
  // control register
  // ----------------------------------------
  logic [7:0] ctrl_ff;
  logic       wr_busy;
  logic       cmd_step;
  logic       cmd_wstart;
  logic       cmd_wstop;
  logic       cmd_wpulse;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_ff <= `CTRL_RESET;
    end else if (wr_ph_ff && addr_ff == `REG_CTRL) begin
      // drive selection held while a write is under way
      ctrl_ff <= {hwdata[7:1], wr_busy ? ctrl_ff[`CTRL_DRIVE] : hwdata[`CTRL_DRIVE]};
    end
  end

  assign cmd_step   = wr_ph_ff && addr_ff == `REG_CMD && hwdata[1:0] == `CMD_STEP;
  assign cmd_wstart = wr_ph_ff && addr_ff == `REG_CMD && hwdata[1:0] == `CMD_WR_START;
  assign cmd_wstop  = wr_ph_ff && addr_ff == `REG_CMD && hwdata[1:0] == `CMD_WR_STOP;
  assign cmd_wpulse = wr_ph_ff && addr_ff == `REG_WDATA;

  // ----------------------------------------
  // spin-up timer
  // ----------------------------------------
  logic [31:0] spin_ff;
  logic        spin_drv_ff;

  // drive that the spin-up count belongs to
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      spin_drv_ff <= 1'b0;
    end else begin
      spin_drv_ff <= ctrl_ff[`CTRL_DRIVE];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      spin_ff <= 32'h0;
    end else if (!ctrl_ff[`CTRL_MOTOR] || spin_drv_ff != ctrl_ff[`CTRL_DRIVE]) begin
      spin_ff <= SPINUP_CYC;
    end else if (spin_ff != 32'h0) begin
      spin_ff <= spin_ff - 32'h1;
    end
  end

  // ----------------------------------------
  // step pulse and settle timer
  // ----------------------------------------
  logic [31:0] step_ff;
  logic [15:0] pulse_ff;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      step_ff  <= 32'h0;
      pulse_ff <= 16'h0;
    end else if (cmd_step && !wr_busy) begin
      step_ff  <= STEP_CYC;
      pulse_ff <= 16'(PULSE_CYC);
    end else begin
      if (step_ff != 32'h0) step_ff <= step_ff - 32'h1;
      if (pulse_ff != 16'h0) pulse_ff <= pulse_ff - 16'h1;
    end
  end

  // ----------------------------------------
  // write sequence
  // ----------------------------------------
  wr_state_t   wst_ff;
  wr_state_t   nxt_wst;
  logic [31:0] busy_ff;
  logic [31:0] rset_ff;
  logic        unit_ready;
  logic [3:0]  wpulse_ff;
  logic        tail_sent_ff;

  // ready once the spin-up, step pulse and step settle delays have run out
  assign unit_ready = ctrl_ff[`CTRL_MOTOR] && spin_ff == 32'h0 && step_ff == 32'h0 &&
                      pulse_ff == 16'h0 && spin_drv_ff == ctrl_ff[`CTRL_DRIVE];

  always_comb begin
    nxt_wst = wst_ff;
    case (wst_ff)
      wr_idle: if (cmd_wstart && unit_ready) nxt_wst = wr_gate;
      wr_gate: if (cmd_wstop) nxt_wst = wr_tail;
      wr_tail: if (tail_sent_ff && wpulse_ff == 4'h0) nxt_wst = wr_trim;
      wr_trim: if (busy_ff == 32'h0) nxt_wst = wr_idle;
      default: nxt_wst = wr_idle;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) wst_ff <= wr_idle;
    else          wst_ff <= nxt_wst;
  end

  // trailing pulse after the last data pulse
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wpulse_ff <= 4'h0;
    end else if (cmd_wpulse && wst_ff == wr_gate) begin
      wpulse_ff <= 4'h8;
    end else if (wst_ff == wr_tail && !tail_sent_ff && wpulse_ff == 4'h0) begin
      wpulse_ff <= 4'h8;
    end else if (wpulse_ff != 4'h0) begin
      wpulse_ff <= wpulse_ff - 4'h1;
    end
  end

  // extra pulse only after the last data pulse has spaced out
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tail_sent_ff <= 1'b0;
    end else if (wst_ff != wr_tail) begin
      tail_sent_ff <= 1'b0;
    end else if (wpulse_ff == 4'h0) begin
      tail_sent_ff <= 1'b1;
    end
  end

  // busy covers trim-on and trim-off delays
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      busy_ff <= 32'h0;
    end else if (wst_ff == wr_tail && nxt_wst == wr_trim) begin
      busy_ff <= BUSY_CYC;
    end else if (busy_ff != 32'h0) begin
      busy_ff <= busy_ff - 32'h1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rset_ff <= 32'h0;
    end else if (wst_ff != wr_idle) begin
      rset_ff <= RSETTLE_CYC;
    end else if (rset_ff != 32'h0) begin
      rset_ff <= rset_ff - 32'h1;
    end
  end

  assign wr_busy = wst_ff != wr_idle;

  // ----------------------------------------
  // status synchronisers
  // ----------------------------------------
  drive_sts_t sts_meta_ff [2];
  drive_sts_t sts_ff      [2];

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_sync
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          sts_meta_ff[gi] <= 4'hF;
          sts_ff[gi]      <= 4'hF;
        end else begin
          sts_meta_ff[gi] <= (gi == 0) ? drv0_sts : drv1_sts;
          sts_ff[gi]      <= sts_meta_ff[gi];
        end
      end
    end
  endgenerate

  drive_sts_t act_sts;
  logic [15:0] rcount_ff;
  logic        rd_prev_ff;

  assign act_sts = sts_ff[ctrl_ff[`CTRL_DRIVE]];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_prev_ff <= 1'b1;
      rcount_ff  <= 16'h0;
      rd_data_n  <= 1'b1;
    end else begin
      rd_prev_ff <= act_sts.rdata_n;
      rd_data_n  <= act_sts.rdata_n;
      if (rd_prev_ff && !act_sts.rdata_n && read_ok) rcount_ff <= rcount_ff + 16'h1;
    end
  end

  assign read_ok = unit_ready && !wr_busy && rset_ff == 32'h0;

  // ----------------------------------------
  // drive control outputs
  // ----------------------------------------
  drive_ctl_t ctl;

  always_comb begin
    ctl.sel_n     = 1'b0;
    ctl.motor_n   = !ctrl_ff[`CTRL_MOTOR];
    ctl.side      = ctrl_ff[`CTRL_SIDE];
    ctl.dir       = ctrl_ff[`CTRL_DIR];
    ctl.step_n    = !(pulse_ff != 16'h0);
    ctl.wr_en_n   = !(wst_ff == wr_gate || wst_ff == wr_tail);
    ctl.wr_data_n = !(wpulse_ff[3]);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      drv0_ctl <= 7'h7F;
      drv1_ctl <= 7'h7F;
    end else begin
      drv0_ctl <= ctrl_ff[`CTRL_DRIVE] ? 7'h7F : ctl;
      drv1_ctl <= ctrl_ff[`CTRL_DRIVE] ? ctl : 7'h7F;
    end
  end

  // ----------------------------------------
  // read data mux
  // ----------------------------------------
  always_comb begin
    case (addr_ff)
      `REG_CTRL:   hrdata = {24'h0, ctrl_ff};
      `REG_STATUS: hrdata = {24'h0, read_ok, unit_ready, wr_busy, 1'b0,
                             ~act_sts.index_n, ~act_sts.trk0_n, ~act_sts.wprot_n,
                             ~act_sts.rdata_n};
      `REG_RCOUNT: hrdata = {16'h0, rcount_ff};
      default:     hrdata = 32'h0;
    endcase
  end
endmodule : fdd_seq
`default_nettype wire

//--- sim/fdd_drv_model.sv
/*
  behavioural drive model for the sequencer bench.
  assumes one bench clock; lines idle high with pull-ups.
*/
`timescale 1ns/1ps
`default_nettype none
module fdd_drv_model #(
  parameter bit WPROT        = 1'b0,
  parameter int TRIM_ON_CYC  = 10,
  parameter int TRIM_OFF_CYC = 20
) (
  input  wire logic                    clk,
  input  wire fdd_seq_pkg::drive_ctl_t ctl,
  input  wire logic                    kick,
  output fdd_seq_pkg::drive_sts_t      sts,
  output int                           steps,
  output int                           flux,
  output logic                         wbusy
);
  import fdd_seq_pkg::*;
  int         trk    = 0;
  int         rc     = 0;
  logic [1:0] ph     = 2'h0;
  logic [7:0] ic     = 8'h00;
  logic       pwr_ok = 1'b1;
  int         won    = 0;
  int         woff   = 0;
  logic       trim   = 1'b0;
  wire        sel    = !ctl.sel_n && pwr_ok;
  initial begin
    steps = 0;
    flux = 0;
  end
  // ----------------------------------------
  // head and write path
  // ----------------------------------------
  always @(negedge ctl.step_n) if (sel && ctl.wr_en_n) begin
    steps++;
    if (ctl.dir) trk++;
    else if (trk > 0) trk--;
    ph = ph + (ctl.dir ? 2'h1 : 2'h3);
  end
  always @(negedge ctl.wr_data_n) if (sel && !ctl.wr_en_n) flux++;
  always @(posedge clk) begin
    won  <= ctl.wr_en_n ? 0 : won + 1;
    woff <= ctl.wr_en_n ? woff + 1 : 0;
    if (won == TRIM_ON_CYC) trim <= 1'b1;
    else if (woff == TRIM_OFF_CYC) trim <= 1'b0;
  end
  assign wbusy = !ctl.wr_en_n || trim;
  // ----------------------------------------
  // status lines
  // ----------------------------------------
  always @(posedge clk) begin
    ic <= ic + 8'h01;
    if (kick) rc <= 200;
    else if (rc > 0) rc <= rc - 1;
  end
  assign sts = !sel ? 4'hF : {!(!ctl.motor_n && ic == 8'h00),
                              !(trk == 0 && ph == 2'h0), !WPROT, rc == 0};
endmodule : fdd_drv_model
`default_nettype wire

//--- sim/fdd_seq_asserts.sv
/*
  port checker for the sequencer.
  assumes it is bound to the sequencer top.
*/
`timescale 1ns/1ps
`default_nettype none
module fdd_seq_asserts #(
  parameter int unsigned SPINUP_CYC  = 50,
  parameter int unsigned STEP_CYC    = 40,
  parameter int unsigned BUSY_CYC    = 30,
  parameter int unsigned RSETTLE_CYC = 20
) (
  input wire logic                    hclk,
  input wire logic                    hresetn,
  input wire fdd_seq_pkg::drive_ctl_t drv0_ctl,
  input wire fdd_seq_pkg::drive_ctl_t drv1_ctl,
  input wire logic                    read_ok
);
  import fdd_seq_pkg::*;
  drive_ctl_t  a;
  int unsigned mc_ff, sc_ff, wc_ff;
  assign a = drv0_ctl.sel_n ? drv1_ctl : drv0_ctl;
  // ----------------------------------------
  // elapsed-time counters
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn) mc_ff <= 0;
    else mc_ff <= (a.motor_n || $changed(drv0_ctl.sel_n)) ? 0 : mc_ff + 1;
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn) sc_ff <= STEP_CYC;
    else sc_ff <= $fell(a.step_n) ? 0 : sc_ff + 1;
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn) wc_ff <= BUSY_CYC + RSETTLE_CYC;
    else wc_ff <= a.wr_en_n ? wc_ff + 1 : 0;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_one_drive: assert property (drv0_ctl.sel_n || drv1_ctl.sel_n)
    else $error("both drives selected");
  a_idle_drive: assert property ((drv0_ctl.sel_n |-> &drv0_ctl) and
    (drv1_ctl.sel_n |-> &drv1_ctl)) else $error("idle drive not quiet");
  a_wr_motor: assert property (!a.wr_en_n |-> !a.motor_n)
    else $error("write without motor");
  a_wr_sel: assert property (!a.wr_en_n |-> !a.sel_n)
    else $error("write without select");
  a_spin_wait: assert property ($fell(a.wr_en_n) |-> mc_ff >= SPINUP_CYC - 1)
    else $error("write before spin-up");
  a_step_wait: assert property ($fell(a.wr_en_n) |-> sc_ff >= STEP_CYC - 1)
    else $error("write before settle");
  a_no_step_wr: assert property (!a.wr_en_n |-> a.step_n)
    else $error("step during write");
  a_read_quiet: assert property (read_ok |-> a.wr_en_n && wc_ff >= BUSY_CYC + RSETTLE_CYC)
    else $error("read ready too soon");
  c_write: cover property ($fell(a.wr_en_n));
  c_step: cover property ($fell(a.step_n));
  c_read: cover property ($rose(read_ok));
endmodule : fdd_seq_asserts
bind fdd_seq fdd_seq_asserts #(.SPINUP_CYC(SPINUP_CYC), .STEP_CYC(STEP_CYC),
  .BUSY_CYC(BUSY_CYC), .RSETTLE_CYC(RSETTLE_CYC)) fdd_seq_asserts_inst (
  .hclk, .hresetn, .drv0_ctl, .drv1_ctl, .read_ok);
`default_nettype wire

//--- sim/fdd_seq_tb.sv
/*
  register-level bench for the sequencer.
  assumes the drive model and the checker are compiled alongside.
*/
`timescale 1ns/1ps
`default_nettype none
`include "fdd_seq_defs.svh"
module fdd_seq_tb;
  import fdd_seq_pkg::*;
  logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, k0 = 0, k1 = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, q;
  logic [1:0]  htrans = 0;
  logic [2:0]  hsize = 3'h2;
  logic        hreadyout, hresp, rd_data_n, read_ok, wb0, wb1;
  drive_ctl_t  c0, c1;
  drive_sts_t  s0, s1;
  int          n_errors = 0, n_compared = 0, st0, fl0, st1, fl1;
  always #2.5 hclk = ~hclk;
  fdd_seq #(50, 40, 30, 20) fdd_seq_inst (.hclk, .hresetn, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
    .drv0_ctl(c0), .drv1_ctl(c1), .drv0_sts(s0), .drv1_sts(s1), .rd_data_n, .read_ok);
  fdd_drv_model #(1'b1) fdd_drv_model_inst (.clk(hclk), .ctl(c0), .kick(k0),
    .sts(s0), .steps(st0), .flux(fl0), .wbusy(wb0));
  fdd_drv_model fdd_drv_model_inst_b (.clk(hclk), .ctl(c1), .kick(k1),
    .sts(s1), .steps(st1), .flux(fl1), .wbusy(wb1));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task wrap_up();
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : wrap_up
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      n_errors++;
      $display("CHECK FAILED %s exp %h got %h", n, e, s);
    end
  endtask : chk
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    i = 0;
    htrans <= 2'h2; hsel <= 1'b1; hwrite <= w; haddr <= {24'h0, a};
    do begin @(posedge hclk); i++; end while (hreadyout !== 1'b1 && i < 50);
    htrans <= 2'h0; hsel <= 1'b0; hwdata <= d;
    do begin @(posedge hclk); i++; end while (hreadyout !== 1'b1 && i < 50);
    q = hrdata;
    if (i >= 50) begin
      n_errors++;
      wrap_up();
    end
  endtask : xfer
  initial begin
    #100us;
    n_errors++;
    wrap_up();
  end
  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk("ctl1", c1, 32'h7F);
    xfer(0, 8'h20, 0); chk("unmapped", q, 0);
    chk("resp", {hresp, hreadyout}, 2'h1);
    xfer(1, `REG_CTRL, 32'h2); xfer(1, `REG_CMD, 32'h2); repeat (3) @(posedge hclk);
    chk("early wen", c0.wr_en_n, 1);
    chk("sel", {c0.sel_n, c0.motor_n}, 0);
    xfer(0, `REG_STATUS, 0); chk("trk0 wp", q[2:1], 2'h3);
    repeat (60) @(posedge hclk);
    xfer(1, `REG_CMD, 32'h2); repeat (3) @(posedge hclk);
    chk("wen", c0.wr_en_n, 0);
    xfer(1, `REG_CMD, 32'h1);
    repeat (3) xfer(1, `REG_WDATA, 32'h1);
    xfer(1, `REG_CMD, 32'h3); repeat (20) @(posedge hclk);
    chk("steps", st0, 0);
    chk("flux", fl0, 4);
    xfer(0, `REG_STATUS, 0); chk("rd early", q[7], 0);
    chk("drv busy", wb0, 1);
    repeat (60) @(posedge hclk);
    xfer(0, `REG_STATUS, 0); chk("rd ok", {q[7], q[5]}, 2'h2);
    chk("drv idle", wb0, 0);
    xfer(1, `REG_CTRL, 32'hA); xfer(1, `REG_CMD, 32'h1); xfer(1, `REG_CMD, 32'h2);
    repeat (3) @(posedge hclk);
    chk("step wen", {st0[1:0], c0.wr_en_n}, 3'h3);
    xfer(0, `REG_STATUS, 0); chk("off trk0", q[2], 0);
    repeat (200) @(posedge hclk);
    xfer(1, `REG_CMD, 32'h2); repeat (3) @(posedge hclk);
    chk("late wen", c0.wr_en_n, 0);
    xfer(1, `REG_CMD, 32'h3); repeat (60) @(posedge hclk);
    xfer(1, `REG_CTRL, 32'h7); repeat (3) @(posedge hclk);
    chk("drv1", {c0, c1.sel_n, c1.side}, 9'h1FD);
    chk("spin drv1", read_ok, 0);
    repeat (60) @(posedge hclk);
    chk("read_ok", read_ok, 1);
    k1 <= 1'b1; @(posedge hclk); k1 <= 1'b0; repeat (10) @(posedge hclk);
    chk("rd pulse", rd_data_n, 0);
    repeat (290) @(posedge hclk);
    chk("rd idle", rd_data_n, 1);
    xfer(0, `REG_RCOUNT, 0); chk("rcount", q, 1);
    wrap_up();
  end
endmodule : fdd_seq_tb
`default_nettype wire
